//--- logic/cprb_pkg.sv
// package of constants and carriers for the control-port register bank
package cprb_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int COEF_DEPTH = 16;
    localparam int COEF_AW = 4;
    localparam logic [7:0] OFS_PAGE_SELECT = 8'h00;
    localparam logic [7:0] OFS_RESET_CONTROL = 8'h01;
    localparam logic [7:0] OFS_DEVICE_CONTROL_ONE = 8'h02;
    localparam logic [7:0] OFS_DEVICE_CONTROL_TWO = 8'h03;
    localparam logic [7:0] OFS_PAGE_INCREMENT_CONTROL = 8'h0f;
    localparam int FULL_CORE_RESET_BIT = 4;
    localparam int REG_RESET_BIT = 0;
    localparam logic [7:0] RESET_CONTROL_RESET = 8'h00;
    localparam logic [7:0] RESET_CONTROL_RW_MASK = 8'he0;
    localparam logic [7:0] DEVICE_CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] DEVICE_CONTROL_TWO_RESET = 8'h10;
    localparam logic [7:0] PAGE_INCREMENT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PAGE_SELECT_RESET = 8'h00;
    localparam logic [7:0] GENERAL_RESET = 8'h00;
    localparam logic [7:0] GENERAL_PAGE = 8'h00;

    // offsets of the plain read/write registers held in the general array
    localparam int NUM_GEN = 47;
    localparam logic [7:0] GEN_OFS [NUM_GEN] = '{
        8'h28, 8'h29, 8'h30, 8'h31, 8'h33, 8'h34, 8'h35, 8'h37, 8'h38, 8'h39,
        8'h40, 8'h46, 8'h4c, 8'h4e, 8'h4f, 8'h50, 8'h51, 8'h53, 8'h54, 8'h55,
        8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5e, 8'h60, 8'h61,
        8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h69, 8'h6a, 8'h6b, 8'h6c,
        8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h0f, 8'h02, 8'h03
    };

    typedef enum logic [1:0] {
        CPRB_WIPE_IDLE = 2'b00,
        CPRB_WIPE_RUN = 2'b01,
        CPRB_WIPE_DONE = 2'b11
    } cprb_wipe_e;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
    } cprb_req_s;

    typedef struct packed {
        logic rdValid;
        logic [DATA_W-1:0] rdData;
        logic unmapped;
    } cprb_rsp_s;
endpackage

//--- logic/cprb_coef_ram.sv
// coefficient store with a sequential wipe engine
`timescale 1ns/10ps
module cprb_coef_ram (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wipe request and state
    input wire logic wipeStart,
    output logic wipeBusy,
    // write port
    input wire logic wrEn,
    input wire logic [cprb_pkg::COEF_AW-1:0] wrAddr,
    input wire logic [cprb_pkg::DATA_W-1:0] wrData,
    // read port
    input wire logic [cprb_pkg::COEF_AW-1:0] rdAddr,
    output logic [cprb_pkg::DATA_W-1:0] rdData
);
    typedef struct packed {
        cprb_pkg::cprb_wipe_e wipe;
        logic [cprb_pkg::COEF_AW-1:0] idx;
        logic [cprb_pkg::COEF_DEPTH-1:0][cprb_pkg::DATA_W-1:0] mem;
        logic [cprb_pkg::DATA_W-1:0] rd;
    } cprb_ram_s;

    cprb_ram_s st_r;
    cprb_ram_s st_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.rd = st_r.mem[rdAddr];
        case (st_r.wipe)
            cprb_pkg::CPRB_WIPE_IDLE: begin
                if (wipeStart) begin
                    st_nxt.wipe = cprb_pkg::CPRB_WIPE_RUN;
                    st_nxt.idx = '0;
                end else if (wrEn) begin
                    st_nxt.mem[wrAddr] = wrData;
                end
            end
            cprb_pkg::CPRB_WIPE_RUN: begin
                // one word per cycle; host writes are dropped while wiping
                st_nxt.mem[st_r.idx] = '0;
                if (st_r.idx == cprb_pkg::COEF_AW'(cprb_pkg::COEF_DEPTH - 1)) begin
                    st_nxt.wipe = cprb_pkg::CPRB_WIPE_DONE;
                end
                st_nxt.idx = st_r.idx + 1'b1;
            end
            cprb_pkg::CPRB_WIPE_DONE: begin
                st_nxt.wipe = cprb_pkg::CPRB_WIPE_IDLE;
            end
            default: begin
                st_nxt.wipe = cprb_pkg::CPRB_WIPE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wipeBusy = (st_r.wipe != cprb_pkg::CPRB_WIPE_IDLE);
    assign rdData = st_r.rd;
endmodule

//--- logic/cprb_top.sv
// control-port register bank with full-core and register-only reset
`timescale 1ns/10ps
module cprb_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register access port
    input wire cprb_pkg::cprb_req_s req,
    output cprb_pkg::cprb_rsp_s rsp,
    // coefficient access; writes only on a selected non-zero page, reads on any page
    input wire logic coefWrEn,
    input wire logic [cprb_pkg::COEF_AW-1:0] coefAddr,
    input wire logic [cprb_pkg::DATA_W-1:0] coefWrData,
    output logic [cprb_pkg::DATA_W-1:0] coefRdData,
    // control outputs
    output logic [cprb_pkg::DATA_W-1:0] pageSelect,
    output logic [cprb_pkg::DATA_W-1:0] deviceControlOne,
    output logic [cprb_pkg::DATA_W-1:0] deviceControlTwo,
    output logic coreResetPulse,
    output logic coefWipeBusy
);
    typedef struct packed {
        logic [cprb_pkg::DATA_W-1:0] resetUpper;
        logic [cprb_pkg::DATA_W-1:0] page;
        logic [cprb_pkg::NUM_GEN-1:0][cprb_pkg::DATA_W-1:0] gen;
        cprb_pkg::cprb_rsp_s rsp;
        logic coreRst;
    } cprb_top_s;

    cprb_top_s st_r;
    cprb_top_s st_nxt;
    logic wipeBusy;

    ////////////////////////////////////////////////////////////////////////
    // index of a general register, or NUM_GEN when none matches
    function automatic int genIndex(input logic [cprb_pkg::ADDR_W-1:0] a);
        int r;
        r = cprb_pkg::NUM_GEN;
        for (int i = 0; i < cprb_pkg::NUM_GEN; i++) begin
            if (cprb_pkg::GEN_OFS[i] == a) begin
                r = i;
            end
        end
        return r;
    endfunction

    // value each general register takes on any reset
    function automatic logic [cprb_pkg::DATA_W-1:0] genReset(input int i);
        logic [cprb_pkg::DATA_W-1:0] v;
        v = cprb_pkg::GENERAL_RESET;
        if (cprb_pkg::GEN_OFS[i] == cprb_pkg::OFS_DEVICE_CONTROL_ONE) begin
            v = cprb_pkg::DEVICE_CONTROL_ONE_RESET;
        end else if (cprb_pkg::GEN_OFS[i] == cprb_pkg::OFS_DEVICE_CONTROL_TWO) begin
            v = cprb_pkg::DEVICE_CONTROL_TWO_RESET;
        end else if (cprb_pkg::GEN_OFS[i] == cprb_pkg::OFS_PAGE_INCREMENT_CONTROL) begin
            v = cprb_pkg::PAGE_INCREMENT_CONTROL_RESET;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        int gi;
        logic onPageZero;
        logic regReset;
        gi = genIndex(req.addr);
        onPageZero = (st_r.page == cprb_pkg::GENERAL_PAGE);
        regReset = 1'b0;
        st_nxt = st_r;
        st_nxt.rsp = '0;
        st_nxt.coreRst = 1'b0;

        if (req.rdEn) begin
            st_nxt.rsp.rdValid = 1'b1;
            if (req.addr == cprb_pkg::OFS_PAGE_SELECT) begin
                st_nxt.rsp.rdData = st_r.page;
            end else if (!onPageZero) begin
                st_nxt.rsp.rdData = '0;
                st_nxt.rsp.unmapped = 1'b1;
            end else if (req.addr == cprb_pkg::OFS_RESET_CONTROL) begin
                // reset bits and bits 3-1 always read zero
                st_nxt.rsp.rdData = st_r.resetUpper & cprb_pkg::RESET_CONTROL_RW_MASK;
            end else if (gi < cprb_pkg::NUM_GEN) begin
                st_nxt.rsp.rdData = st_r.gen[gi];
            end else begin
                st_nxt.rsp.rdData = '0;
                st_nxt.rsp.unmapped = 1'b1;
            end
        end

        if (req.wrEn) begin
            if (req.addr == cprb_pkg::OFS_PAGE_SELECT) begin
                st_nxt.page = req.wrData;
            end else if (onPageZero && req.addr == cprb_pkg::OFS_RESET_CONTROL) begin
                st_nxt.resetUpper = req.wrData & cprb_pkg::RESET_CONTROL_RW_MASK;
                if (req.wrData[cprb_pkg::FULL_CORE_RESET_BIT]) begin
                    st_nxt.coreRst = 1'b1;
                    regReset = 1'b1;
                end
                if (req.wrData[cprb_pkg::REG_RESET_BIT]) begin
                    regReset = 1'b1;
                end
            end else if (onPageZero && gi < cprb_pkg::NUM_GEN) begin
                st_nxt.gen[gi] = req.wrData;
            end
            // unmapped offsets are ignored so their contents never change
        end

        // zero written to the reset bits leaves regReset low
        if (regReset) begin
            st_nxt.resetUpper = cprb_pkg::RESET_CONTROL_RESET;
            st_nxt.page = cprb_pkg::PAGE_SELECT_RESET;
            for (int i = 0; i < cprb_pkg::NUM_GEN; i++) begin
                st_nxt.gen[i] = genReset(i);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.resetUpper <= cprb_pkg::RESET_CONTROL_RESET;
            st_r.page <= cprb_pkg::PAGE_SELECT_RESET;
            for (int i = 0; i < cprb_pkg::NUM_GEN; i++) begin
                st_r.gen[i] <= genReset(i);
            end
            st_r.rsp <= '0;
            st_r.coreRst <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    cprb_coef_ram uCoef (
        .clk(clk),
        .rst_n(rst_n),
        .wipeStart(st_r.coreRst),
        .wipeBusy(wipeBusy),
        .wrEn(coefWrEn && st_r.page != cprb_pkg::GENERAL_PAGE),
        .wrAddr(coefAddr),
        .wrData(coefWrData),
        .rdAddr(coefAddr),
        .rdData(coefRdData)
    );

    assign rsp = st_r.rsp;
    assign pageSelect = st_r.page;
    assign deviceControlOne = st_r.gen[cprb_pkg::NUM_GEN-2];
    assign deviceControlTwo = st_r.gen[cprb_pkg::NUM_GEN-1];
    assign coreResetPulse = st_r.coreRst;
    assign coefWipeBusy = wipeBusy;
endmodule

//--- tb/cprb_checker.sv
// port-level assertions for the control-port register bank
`timescale 1ns/10ps
module cprb_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire cprb_pkg::cprb_req_s req,
    input wire cprb_pkg::cprb_rsp_s rsp,
    // control outputs
    input wire logic [7:0] pageSelect,
    input wire logic [7:0] deviceControlOne,
    input wire logic [7:0] deviceControlTwo,
    input wire logic coreResetPulse,
    input wire logic coefWipeBusy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic ctlWr;
    assign ctlWr = req.wrEn && req.addr == 8'h01 && pageSelect == 8'h00;
    sequence s_wipe_run;
        coefWipeBusy [*8] ##1 coefWipeBusy [*8] ##1 coefWipeBusy ##1 !coefWipeBusy;
    endsequence
    sequence s_regs_home;
        deviceControlOne == 8'h00 && deviceControlTwo == 8'h10 && pageSelect == 8'h00;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer_once: assert property (req.rdEn |=> rsp.rdValid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!req.rdEn |=> !rsp.rdValid)
        else $error("answer without read");
    a_unmapped_reads_zero: assert property (rsp.unmapped |-> rsp.rdValid && rsp.rdData == 8'h00)
        else $error("unmapped read not zero");
    a_core_pulse_cause: assert property (ctlWr && req.wrData[4] |=> coreResetPulse ##0 s_regs_home)
        else $error("full reset missing");
    a_pulse_single: assert property (coreResetPulse |=> !coreResetPulse)
        else $error("pulse too long");
    a_wipe_length: assert property (coreResetPulse |=> s_wipe_run)
        else $error("wipe length wrong");
    a_reg_reset_home: assert property (ctlWr && req.wrData[0] |=> s_regs_home)
        else $error("register reset missing");
    a_no_pulse_regonly: assert property (ctlWr && !req.wrData[4] |=> !coreResetPulse)
        else $error("pulse without cause");
    a_ctl_bits_low: assert property (
        req.rdEn && req.addr == 8'h01 && pageSelect == 8'h00 |=> rsp.rdData[4:0] == 5'h00)
        else $error("reset control low bits set");
    a_zero_bits_hold: assert property (
        ctlWr && !req.wrData[4] && !req.wrData[0] |=> $stable(deviceControlOne))
        else $error("zero write changed state");
    a_page_gate: assert property (
        req.wrEn && req.addr == 8'h02 && pageSelect != 8'h00 |=> $stable(deviceControlOne))
        else $error("write off page zero taken");
endmodule
bind cprb_top cprb_checker u_checker (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .pageSelect(pageSelect), .deviceControlOne(deviceControlOne),
    .deviceControlTwo(deviceControlTwo), .coreResetPulse(coreResetPulse),
    .coefWipeBusy(coefWipeBusy));

//--- tb/cprb_host_model.sv
// host-side model driving register and coefficient accesses
`timescale 1ns/10ps
module cprb_host_model (
    // clock
    input wire logic clk,
    // register port
    output cprb_pkg::cprb_req_s req,
    input wire cprb_pkg::cprb_rsp_s rsp,
    // coefficient port
    output logic coefWrEn,
    output logic [3:0] coefAddr,
    output logic [7:0] coefWrData,
    input wire logic [7:0] coefRdData
);
    initial begin
        req = '0;
        coefWrEn = 1'b0;
        coefAddr = 4'h0;
        coefWrData = 8'h00;
    end
    // released lines show the inverse of the last value
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic u);
        @(negedge clk);
        req = '{wrEn: w, rdEn: !w, addr: a, wrData: d};
        @(negedge clk);
        q = rsp.rdData;
        u = rsp.unmapped;
        req = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
    endtask
    task automatic coef(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(negedge clk);
        coefWrEn = w;
        coefAddr = a;
        coefWrData = d;
        @(negedge clk);
        q = coefRdData;
        coefWrEn = 1'b0;
        coefWrData = ~d;
    endtask
endmodule

//--- tb/control_port_reset_register_bank_tb.sv
// self-checking bench for the control-port register bank
`timescale 1ns/10ps
module control_port_reset_register_bank_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cprb_pkg::cprb_req_s req;
    cprb_pkg::cprb_rsp_s rsp;
    logic coefWrEn;
    logic [3:0] coefAddr;
    logic [7:0] coefWrData, coefRdData, pageSelect, deviceControlOne, deviceControlTwo;
    logic coreResetPulse, coefWipeBusy, u;
    logic [7:0] q, v;
    logic [7:0] shadow [cprb_pkg::NUM_GEN];
    int n_errors = 0;
    int n_checks = 0;
    cprb_top dut (.clk, .rst_n, .req, .rsp, .coefWrEn, .coefAddr, .coefWrData, .coefRdData,
        .pageSelect, .deviceControlOne, .deviceControlTwo, .coreResetPulse, .coefWipeBusy);
    cprb_host_model host (.clk, .req, .rsp, .coefWrEn, .coefAddr, .coefWrData, .coefRdData);
    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] expVal);
        n_checks++;
        if (seen !== expVal) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expVal);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q, u);
    endtask
    task automatic rd(input logic [7:0] a);
        host.access(1'b0, a, 8'h00, q, u);
    endtask
    function automatic logic [7:0] reset_val(input logic [7:0] a);
        return (a == 8'h03) ? 8'h10 : 8'h00;
    endfunction
    task automatic print_verdict();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #(100 * 3000);
        n_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h4a305c25));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h01);
        chk(q, 8'h00);
        for (int i = 0; i < cprb_pkg::NUM_GEN; i++) begin
            rd(cprb_pkg::GEN_OFS[i]);
            chk(q, reset_val(cprb_pkg::GEN_OFS[i]));
            shadow[i] = 8'($urandom());
            wr(cprb_pkg::GEN_OFS[i], shadow[i]);
        end
        for (int i = 0; i < cprb_pkg::NUM_GEN; i++) begin
            rd(cprb_pkg::GEN_OFS[i]);
            chk(q, shadow[i]);
        end
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'he0 : (i == 1) ? 8'h6e : 8'h00;
            wr(8'h01, v);
            rd(8'h01);
            chk(q, v & 8'he0);
            chk(deviceControlOne, shadow[45]);
        end
        rd(8'h04);
        chk({q[7:1], u}, 8'h01);
        wr(8'h00, 8'h05);
        rd(8'h00);
        chk(q, 8'h05);
        rd(8'h02);
        chk({q[7:1], u}, 8'h01);
        wr(8'h02, 8'hff);
        chk(deviceControlOne, shadow[45]);
        v = 8'($urandom());
        host.coef(1'b1, 4'h3, v, q);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'he1);
        chk({deviceControlOne[6:0], coreResetPulse}, 8'h00);
        chk(deviceControlOne, 8'h00);
        chk(deviceControlTwo, 8'h10);
        rd(8'h01);
        chk(q, 8'h00);
        wr(8'h00, 8'h05);
        host.coef(1'b0, 4'h3, 8'h00, q);
        chk(q, v);
        wr(8'h00, 8'h00);
        wr(8'h02, 8'h5a);
        wr(8'h01, 8'h10);
        chk({pageSelect[6:0], coreResetPulse}, 8'h01);
        chk(deviceControlOne, 8'h00);
        @(negedge clk);
        chk({7'h00, coefWipeBusy}, 8'h01);
        repeat (19) @(negedge clk);
        chk({7'h00, coefWipeBusy}, 8'h00);
        rd(8'h01);
        chk(q, 8'h00);
        wr(8'h00, 8'h05);
        host.coef(1'b0, 4'h3, 8'h00, q);
        chk(q, 8'h00);
        // mid-run reset: page select, reset control and offset 03 must come back to their reset values
        wr(8'h00, 8'h00);
        wr(8'h01, 8'ha0);
        wr(8'h03, 8'h3c);
        wr(8'h00, 8'h05);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk(pageSelect, 8'h00);
        rd(8'h01);
        chk(q, 8'h00);
        rd(8'h03);
        chk(q, 8'h10);
        print_verdict();
    end
endmodule
